//--- pkg/emu_ctl_pkg.sv
// Package for the emulator target-boundary control block.
// Assumes a 20 MHz ref_clk and an APB register bus with 32-bit data.
package emu_ctl_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // Register byte offsets
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] CMD_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MAP_OFS  = 8'h0C;
  localparam logic [7:0] OTHR_OFS = 8'h10;
  // Configuration field positions
  localparam int CFG_CLK     = 0;
  localparam int CFG_RRT     = 1;
  localparam int CFG_QBRK    = 2;
  localparam int CFG_TRFSH   = 3;
  localparam int CFG_TBUSACK = 4;
  localparam int CFG_BUSREQ  = 5;
  localparam int CFG_INT     = 6;
  localparam int CFG_NMI     = 7;
  localparam int CFG_WAITEM  = 8;
  localparam int CFG_WRDATA  = 9;
  localparam int CFG_MONCYC  = 10;
  localparam int CFG_ROMBRK  = 11;
  localparam int CFG_CMB     = 12;
  localparam int CFG_MONB_LO = 16;
  // Reset value: internal clock, inputs enabled, everything else off
  localparam logic [31:0] CFG_RST = 32'h0000_01E0;
  // Map word: [31:24] start block, [23:16] end block, [10:8] type, [12] valid, [3:0] term
  localparam int MAP_TERMS = 16;
  localparam int MAP_VALID = 12;
  // Temporary break durations
  localparam int unsigned QUICK_US = 200;
  localparam int unsigned SLOW_MS  = 6;
  localparam int unsigned QUICK_CYC = QUICK_US * (CLK_HZ / 1000000);
  localparam int unsigned SLOW_CYC  = SLOW_MS * (CLK_HZ / 1000);
  // Host command codes
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_RST = 4'h1, CMD_BRK = 4'h2, CMD_RUN = 4'h3,
    CMD_STEP = 4'h4, CMD_REG = 4'h5, CMD_IO = 4'h6, CMD_TMEM = 4'h7,
    CMD_OTHER = 4'h8
  } cmd_e;
  // Memory types
  typedef enum logic [2:0] {
    MT_ERAM = 3'h0, MT_EROM = 3'h1, MT_TRAM = 3'h2, MT_TROM = 3'h3, MT_GRD = 3'h4
  } mem_e;
  // Execution states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00, ST_MON = 2'b01, ST_USER = 2'b10, ST_TEMP = 2'b11
  } run_e;
endpackage : emu_ctl_pkg

//--- rtl/emu_target_ctl.sv
// Target-boundary control of an emulator pod: config over APB, map, gating.
// Assumes target pins arrive asynchronously and the host drives APB on ref_clk.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module emu_target_ctl (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        int_osc_clk,
  input  wire logic        tgt_clk,
  output logic             emu_clk,
  input  wire logic        tgt_busreq_b,
  input  wire logic        tgt_int_b,
  input  wire logic        tgt_nmi_b,
  input  wire logic        tgt_wait_b,
  input  wire logic        cpu_cyc,
  input  wire logic        cpu_io,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rfsh,
  input  wire logic        cpu_busack,
  input  wire logic [15:0] cpu_addr,
  output logic             cpu_busreq,
  output logic             cpu_int,
  output logic             cpu_nmi,
  output logic             cpu_wait,
  output logic             cpu_reset,
  output logic             cyc_to_target,
  output logic             data_oe,
  output logic             tgt_wr_en,
  output logic [15:0]      tgt_addr,
  output logic             emu_sel,
  output logic             brk_req,
  output logic             cmb_brk,
  output logic             ana_strobe,
  output logic             in_monitor
);
  import emu_ctl_pkg::*;

  logic [31:0] cfg;
  logic [31:0] map_tab [MAP_TERMS];
  logic [2:0]  other_type;
  run_e        run_st;
  logic [17:0] tmr;
  logic [1:0]  s_busreq, s_int, s_nmi, s_wait;
  logic        nmi_pend;
  logic        cmd_reject;
  logic        bus_hold;
  logic [3:0]  cmd_last;
  logic [3:0]  mt;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire known  = (paddr == CFG_OFS) | (paddr == CMD_OFS) | (paddr == STAT_OFS)
              | (paddr == MAP_OFS) | (paddr == OTHR_OFS);

  // Type lookup over the sixteen block-granular terms
  function automatic logic [3:0] map_type(input logic [7:0] blk);
    logic [3:0] t;
    t = {1'b0, other_type};
    for (int i = MAP_TERMS - 1; i >= 0; i--) begin
      if (map_tab[i][MAP_VALID] && blk >= map_tab[i][31:24] && blk <= map_tab[i][23:16]) begin
        t = {1'b1, map_tab[i][10:8]};
      end
    end
    return t;
  endfunction : map_type

  // Zero-wait APB slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  assign emu_clk = cfg[CFG_CLK] ? tgt_clk : int_osc_clk;

  // Two-flop synchronisers for target pins
  // Pins idle high, so the reset value matches the idle level and no false request follows
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_busreq <= 2'b11;
      s_int    <= 2'b11;
      s_nmi    <= 2'b11;
      s_wait   <= 2'b11;
    end else begin
      s_busreq <= {s_busreq[0], tgt_busreq_b};
      s_int    <= {s_int[0], tgt_int_b};
      s_nmi    <= {s_nmi[0], tgt_nmi_b};
      s_wait   <= {s_wait[0], tgt_wait_b};
    end
  end

  // Configuration register
  // Whole-word write; unused bits read back as written
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg <= CFG_RST;
    end else if (wr_acc && paddr == CFG_OFS) begin
      cfg <= pwdata;
    end
  end

  // Map table and catch-all type
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < MAP_TERMS; i++) begin
        map_tab[i] <= 32'h0000_0000;
      end
      other_type <= MT_ERAM;
    end else if (wr_acc && paddr == MAP_OFS) begin
      map_tab[pwdata[3:0]] <= pwdata;
    end else if (wr_acc && paddr == OTHR_OFS) begin
      other_type <= pwdata[2:0];
    end
  end

  // Registered copy of cpu_cyc, so emu_sel follows a bus cycle one ref_clk later
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus_hold <= 1'b0;
    end else begin
      bus_hold <= cpu_cyc;
    end
  end

  wire       in_mon    = (run_st != ST_USER);
  wire       mem_cyc   = cpu_cyc & ~cpu_io & ~in_mon;
  wire       is_emu    = mem_cyc & ~mt[2] & ~mt[1];
  wire       is_rom    = mt[0] & (mt[2:0] != MT_GRD);
  wire       cmd_wr    = wr_acc && paddr == CMD_OFS;
  wire [3:0] cmd       = pwdata[3:0];
  wire       clk_chg   = wr_acc && paddr == CFG_OFS && (pwdata[CFG_CLK] != cfg[CFG_CLK]);
  wire       map_chg   = wr_acc && (paddr == MAP_OFS || paddr == OTHR_OFS);
  wire       basic_cmd = (cmd == CMD_RST) | (cmd == CMD_BRK) | (cmd == CMD_RUN)
                       | (cmd == CMD_STEP);
  wire       temp_cmd  = (cmd == CMD_REG) | (cmd == CMD_IO) | (cmd == CMD_TMEM);
  wire       rejected  = cmd_wr && run_st == ST_USER && cfg[CFG_RRT] && !basic_cmd
                       && cmd != CMD_NONE;
  wire       map_brk   = mem_cyc & ((mt[2:0] == MT_GRD)
                       | (is_rom & cpu_wr & cfg[CFG_ROMBRK]));

  // Map lookup in a process, so a rewritten term is seen at once
  always_comb begin
    mt = map_type(cpu_addr[15:8]);
  end

  // Execution state and temporary break timer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      run_st <= ST_RESET;
      tmr    <= 18'h0_0000;
    end else if (clk_chg || map_chg) begin
      run_st <= ST_RESET;
      tmr    <= 18'h0_0000;
    end else begin
      case (run_st)
        ST_RESET, ST_MON: begin
          // A reset command from the monitor returns the processor to reset
          if (cmd_wr && (cmd == CMD_RUN || cmd == CMD_STEP)) run_st <= ST_USER;
          else if (cmd_wr && cmd == CMD_BRK) run_st <= ST_MON;
          else if (cmd_wr && cmd == CMD_RST) run_st <= ST_RESET;
        end
        ST_USER: begin
          if (cmd_wr && cmd == CMD_RST) run_st <= ST_RESET;
          else if (cmd_wr && cmd == CMD_BRK) run_st <= ST_MON;
          else if (map_brk) run_st <= ST_MON;
          else if (cmd_wr && temp_cmd && !rejected) begin
            run_st <= ST_TEMP;
            tmr    <= cfg[CFG_QBRK] ? 18'(QUICK_CYC) : 18'(SLOW_CYC);
          end
        end
        ST_TEMP: begin
          if (tmr <= 18'h0_0001) run_st <= ST_USER;
          tmr <= tmr - 18'h0_0001;
        end
        default: run_st <= ST_RESET;
      endcase
    end
  end

  // Command status: last command and rejection flag
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_reject <= 1'b0;
      cmd_last   <= 4'h0;
    end else if (cmd_wr) begin
      cmd_reject <= rejected;
      cmd_last   <= cmd;
    end
  end

  // NMI latched in monitor, delivered back in user run
  // Clearing on disable keeps a stale request from firing after re-enable
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      nmi_pend <= 1'b0;
    end else if (!cfg[CFG_NMI]) begin
      nmi_pend <= 1'b0;
    end else if (in_mon && !s_nmi[1]) begin
      nmi_pend <= 1'b1;
    end else if (!in_mon) begin
      nmi_pend <= 1'b0;
    end
  end

  // Input gating toward the emulation processor
  always_comb begin
    cpu_busreq = cfg[CFG_BUSREQ] & ~s_busreq[1];
    cpu_int    = cfg[CFG_INT] & ~in_mon & ~s_int[1];
    cpu_nmi    = cfg[CFG_NMI] & ~in_mon & (~s_nmi[1] | nmi_pend);
    cpu_wait   = ~s_wait[1] & cpu_cyc & (cpu_io | in_mon | ~is_emu | cfg[CFG_WAITEM]);
  end

  // Target bus visibility, data drive and address
  always_comb begin
    // hidden monitor unless MONCYC set; I/O cycles hidden the same way
    cyc_to_target = cpu_cyc & (~in_mon | cfg[CFG_MONCYC]);
    tgt_wr_en     = cyc_to_target & cpu_wr & ~(in_mon) & ~(is_rom & ~cpu_io);
    // echo emulation reads; writes and outputs only
    data_oe       = cyc_to_target & ((cpu_wr & ~in_mon)
                  | (cfg[CFG_WRDATA] & is_emu & ~cpu_wr & ~cpu_io));
    // monitor location on top lines, 4K window
    tgt_addr      = in_mon ? {cfg[CFG_MONB_LO +: 4], cpu_addr[11:0]} : cpu_addr;
    emu_sel       = is_emu & bus_hold;
    cpu_reset     = (run_st == ST_RESET);
    in_monitor    = in_mon;
    brk_req       = map_brk;
    // link peers break on slow temporary break only
    cmb_brk       = (run_st == ST_TEMP) & cfg[CFG_CMB] & ~cfg[CFG_QBRK];
    // analyzer feed
    // No processor cycle runs while the bus is granted away
    ana_strobe    = (cpu_cyc & ~cpu_busack & (~cpu_rfsh | cfg[CFG_TRFSH]))
                  | (cpu_busack & cfg[CFG_TBUSACK]);
  end

  // Read data from flip-flops
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        CFG_OFS:  prdata <= cfg;
        STAT_OFS: prdata <= {24'h00_0000, cmd_last, cmd_reject, nmi_pend, 2'(run_st)};
        OTHR_OFS: prdata <= {29'h0000_0000, other_type};
        default:  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Rule checks; each label guards one rule
  // map edit resets
  reset_on_map_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    map_chg |=> run_st == ST_RESET) else $error("map change did not reset");

  int_blocked_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    in_mon |-> !cpu_int) else $error("interrupt passed in monitor");

  hidden_mon_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    in_mon && !cfg[CFG_MONCYC] |-> !cyc_to_target) else $error("monitor cycle visible");

  mon_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    in_mon |-> tgt_addr[15:12] == cfg[19:16]) else $error("monitor base wrong");

  io_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cpu_cyc && cpu_io && !s_wait[1] |-> cpu_wait) else $error("target wait lost");

  rrt_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rejected && !map_brk |=> run_st == ST_USER && cmd_reject) else $error("restricted cmd taken");

  guard_brk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mem_cyc && mt[2:0] == MT_GRD && !map_chg && !clk_chg && !cmd_wr |=> run_st == ST_MON)
    else $error("guarded access no break");

  temp_brk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    run_st == ST_USER && cmd_wr && temp_cmd && !rejected && !map_chg && !clk_chg
    && !map_brk |=> run_st == ST_TEMP) else $error("no temporary break");

  busreq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !cfg[CFG_BUSREQ] |-> !cpu_busreq) else $error("bus request not gated");

  nmi_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    in_mon && cfg[CFG_NMI] && !s_nmi[1] && !(wr_acc && paddr == CFG_OFS)
    |=> nmi_pend) else $error("monitor nmi not held");

  emu_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_emu && !cfg[CFG_WAITEM] |-> !cpu_wait) else $error("emulation wait inserted");

  data_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    data_oe && !cfg[CFG_WRDATA] |-> cpu_wr) else $error("data bus driven on read");

  rfsh_hide_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cpu_rfsh && !cpu_busack && !cfg[CFG_TRFSH] |-> !ana_strobe) else $error("refresh traced");

  rom_brk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mem_cyc && is_rom && cpu_wr && cfg[CFG_ROMBRK] |-> brk_req) else $error("rom write no break");

  cmb_quick_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg[CFG_QBRK] |-> !cmb_brk) else $error("quick break reached link");

  tmr_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tmr <= 18'(SLOW_CYC)) else $error("break timer out of range");

  // Covers for the main scenarios
  quick_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
    run_st == ST_TEMP && cfg[CFG_QBRK]);
  slow_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
    run_st == ST_TEMP && !cfg[CFG_QBRK]);
  nmi_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
    nmi_pend && !in_mon);
  rom_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
    map_brk && cpu_wr);
  reject_cov: cover property (@(posedge ref_clk) disable iff (!rst_b)
    rejected);
endmodule : emu_target_ctl
`default_nettype wire

//--- bench/tgt_board.sv
// Target board model: its own free-running clock and active-low request pins.
// Assumes the bench names the pins to pull low; idle pins rest high on pull-ups.
`timescale 1ns/100ps
`default_nettype none
module tgt_board (
  input  wire logic [3:0] pull_b,
  output logic            tgt_clk,
  output logic            tgt_busreq_b,
  output logic            tgt_int_b,
  output logic            tgt_nmi_b,
  output logic            tgt_wait_b
);
  initial begin
    tgt_clk = 1'b0;
  end
  // Board oscillator, unrelated in phase to the pod's own clock
  always begin
    #31 tgt_clk = ~tgt_clk;
  end
  // Pull-ups hold a released pin high
  assign {tgt_busreq_b, tgt_int_b, tgt_nmi_b, tgt_wait_b} = pull_b;
endmodule : tgt_board
`default_nettype wire

//--- bench/emulator_target_interface_control_bench.sv
// Bench for the pod's target-boundary control: table of gating cases, then hand tests.
// Assumes a zero-wait APB slave and two-flop synchronised target pins.
`timescale 1ns/100ps
`default_nettype none
module emulator_target_interface_control_bench;
  import emu_ctl_pkg::*;
  typedef struct {logic [31:0] cfg; logic [3:0] pb; logic io, wr, rf, ba;
    logic [15:0] a; logic [5:0] ex;} row_s;
  logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, int_osc_clk = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tgt_clk, emu_clk, bq, ib, nb, wb, brk_seen;
  logic cyc = 0, io = 0, wr = 0, rf = 0, ba = 0;
  logic [15:0] addr = 16'h0, tgt_addr;
  logic [3:0] pull_b = 4'hF;
  logic c_bq, c_int, c_nmi, c_wait, c_rst, c_tgt, oe, twe, sel, brk, cmb, ana, inmon;
  int fail_count = 0, compares = 0, n;
  row_s rows [15];
  always #25 ref_clk = ~ref_clk;
  always #62.5 int_osc_clk = ~int_osc_clk;
  tgt_board i_board (.pull_b(pull_b), .tgt_clk(tgt_clk), .tgt_busreq_b(bq),
    .tgt_int_b(ib), .tgt_nmi_b(nb), .tgt_wait_b(wb));
  emu_target_ctl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_osc_clk(int_osc_clk), .tgt_clk(tgt_clk), .emu_clk(emu_clk),
    .tgt_busreq_b(bq), .tgt_int_b(ib), .tgt_nmi_b(nb), .tgt_wait_b(wb), .cpu_cyc(cyc),
    .cpu_io(io), .cpu_wr(wr), .cpu_rfsh(rf), .cpu_busack(ba), .cpu_addr(addr),
    .cpu_busreq(c_bq), .cpu_int(c_int), .cpu_nmi(c_nmi), .cpu_wait(c_wait),
    .cpu_reset(c_rst), .cyc_to_target(c_tgt), .data_oe(oe), .tgt_wr_en(twe),
    .tgt_addr(tgt_addr), .emu_sel(sel), .brk_req(brk), .cmb_brk(cmb), .ana_strobe(ana),
    .in_monitor(inmon));
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk
  task cpu(input logic i, w, r, b, input logic [15:0] ad, input logic [3:0] p);
    @(posedge ref_clk);
    cyc <= 1'b1; io <= i; wr <= w; rf <= r; ba <= b; addr <= ad; pull_b <= p;
    brk_seen = 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      brk_seen = brk_seen | brk;
    end
  endtask : cpu
  task st(input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("status", e, rd & m);
  endtask : st
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
  initial begin
    // Columns: cfg, pins {busreq,int,nmi,wait}_b, io wr rfsh busack, addr,
    // expected {busreq,int,wait,data_oe,emu_sel,ana}
    rows = '{'{32'h1E0, 4'h7, 0, 0, 0, 0, 16'h0100, 6'b100011},
      '{32'h1C0, 4'h7, 0, 0, 0, 0, 16'h0100, 6'b000011},
      '{32'h1E0, 4'hB, 0, 0, 0, 0, 16'h0100, 6'b010011},
      '{32'h1A0, 4'hB, 0, 0, 0, 0, 16'h0100, 6'b000011},
      '{32'h1E0, 4'hE, 0, 0, 0, 0, 16'h0100, 6'b001011},
      '{32'h0E0, 4'hE, 0, 0, 0, 0, 16'h0100, 6'b000011},
      '{32'h0E0, 4'hE, 0, 0, 0, 0, 16'h2000, 6'b001001},
      '{32'h0E0, 4'hE, 1, 0, 0, 0, 16'h0100, 6'b001001},
      '{32'h3E0, 4'hF, 0, 0, 0, 0, 16'h0100, 6'b000111},
      '{32'h1E0, 4'hF, 0, 1, 0, 0, 16'h2000, 6'b000101},
      '{32'h1E0, 4'hF, 1, 1, 0, 0, 16'h0100, 6'b000101},
      '{32'h1E8, 4'hF, 0, 0, 1, 0, 16'h2000, 6'b000001},
      '{32'h1E0, 4'hF, 0, 0, 1, 0, 16'h2000, 6'b000000},
      '{32'h1F0, 4'hF, 0, 0, 0, 1, 16'h2000, 6'b000001},
      '{32'h1E0, 4'hF, 0, 0, 0, 1, 16'h2000, 6'b000000}};
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg reset", 32'h1E0, rd);
    chk("cpu_reset", 1, c_rst);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped read", 0, rd);
    apb(1'b1, MAP_OFS, 32'h000F_1000);
    apb(1'b1, OTHR_OFS, 32'h2);
    apb(1'b1, CMD_OFS, 32'h3);
    st(32'h2, 32'h3);
    foreach (rows[k]) begin
      apb(1'b1, CFG_OFS, rows[k].cfg);
      cpu(rows[k].io, rows[k].wr, rows[k].rf, rows[k].ba, rows[k].a, rows[k].pb);
      chk($sformatf("row %0d", k), rows[k].ex, {c_bq, c_int, c_wait, oe, sel, ana});
    end
    // Quick temporary break: register request while user code runs
    cpu(0, 0, 0, 0, 16'h0100, 4'hF);
    apb(1'b1, CFG_OFS, 32'h11E4);
    apb(1'b1, CMD_OFS, 32'h5);
    st(32'h3, 32'h3);
    chk("cmb quick", 0, cmb);
    n = 0;
    while (inmon === 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("quick span", 1, n > 3980 && n < 4010);
    // Restriction: monitor commands other than the four are refused
    apb(1'b1, CFG_OFS, 32'h11E2);
    for (int c = 5; c <= 8; c++) begin
      apb(1'b1, CMD_OFS, c);
      st(32'hA, 32'hB);
    end
    apb(1'b1, CMD_OFS, 32'h2);
    st(32'h1, 32'hB);
    apb(1'b1, CFG_OFS, 32'h1E0);
    cpu(0, 0, 0, 0, 16'h0123, 4'h9);
    chk("mon hidden", 0, c_tgt);
    chk("mon int", 0, c_int);
    st(32'h4, 32'h4);
    apb(1'b1, CFG_OFS, 32'h0006_05E0);
    cpu(0, 1, 0, 0, 16'h0123, 4'hF);
    chk("mon base", 4'h6, tgt_addr[15:12]);
    chk("mon addr", 12'h123, tgt_addr[11:0]);
    chk("mon write", 0, twe);
    apb(1'b1, CMD_OFS, 32'h3);
    for (n = 0; n < 10 && c_nmi !== 1'b1; n++) @(posedge ref_clk);
    chk("held nmi", 1, c_nmi);
    apb(1'b1, MAP_OFS, 32'h2020_1401);
    st(32'h0, 32'h3);
    apb(1'b1, MAP_OFS, 32'h3030_1302);
    apb(1'b1, CFG_OFS, 32'h9E0);
    apb(1'b1, CMD_OFS, 32'h3);
    cpu(0, 0, 0, 0, 16'h20FF, 4'hF);
    chk("grd last", 1, brk_seen);
    // Park a harmless address in the monitor, then run again
    cpu(0, 0, 0, 0, 16'h2100, 4'hF);
    apb(1'b1, CMD_OFS, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("grd next", 0, brk);
    st(32'h2, 32'h3);
    cpu(0, 1, 0, 0, 16'h3000, 4'hF);
    chk("rom write", 1, brk_seen);
    cpu(0, 0, 0, 0, 16'h3000, 4'hF);
    apb(1'b1, CMD_OFS, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("rom read", 0, brk);
    // Compare just after a source edge so neither clock is mid-change
    @(int_osc_clk);
    #1 chk("int clk", int_osc_clk, emu_clk);
    apb(1'b1, CFG_OFS, 32'h9E1);
    st(32'h0, 32'h3);
    @(tgt_clk);
    #1 chk("tgt clk", tgt_clk, emu_clk);
    // Slow temporary break with coordination on reaches link peers
    apb(1'b1, CFG_OFS, 32'h11E1);
    apb(1'b1, CMD_OFS, 32'h3);
    apb(1'b1, CMD_OFS, 32'h5);
    @(posedge ref_clk);
    chk("cmb slow", 1, cmb);
    test_done();
  end
endmodule : emulator_target_interface_control_bench
`default_nettype wire
